// file: intc_params.svh
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH
`define ADDR_PIN_LEVEL   7'h0F
`define ADDR_EDGE_SEL    7'h1F
`define ADDR_SRC_EN      7'h2F
`define ADDR_SER_REQ     7'h3D
`define ADDR_TMR_REQ     7'h3E
`define ADDR_EXT_REQ     7'h3F
`define VEC_EXT          11'h003
`define VEC_TMR          11'h002
`define VEC_SER          11'h001
`define CYCLE_CLOCKS     16
`define PHASE_CLOCKS     4
`define RECOG_CLOCK      4'h7
`define LAST_CLOCK       4'hF
`define DEFER_CYCLES     2'h2
`define EDGE_RISE        2'h0
`define EDGE_FALL        2'h1
`define STATUS_CLEAR     5'h00
`define EXT_BIT          0
`define TMR_BIT          1
`define SER_BIT          2
`endif

// file: intc_pkg.sv
package intc_pkg;
   typedef logic [10:0] pc_t;
   typedef logic [4:0]  status_t;
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_EXT,
      SRC_TMR,
      SRC_SER
   } source_e;
endpackage

// file: req_flag_if.sv
`timescale 1ns/1ps
interface req_flag_if;
   logic [2:0] events;
   logic [2:0] sw_wr;
   logic [2:0] sw_val;
   logic [2:0] ack;
   logic       tmr_clr;
   logic [2:0] flags;
   modport bank (input events, sw_wr, sw_val, ack, tmr_clr, output flags);
   modport ctrl (output events, sw_wr, sw_val, ack, tmr_clr, input flags);
endinterface

// file: req_flag_bank.sv
`timescale 1ns/1ps
`include "intc_params.svh"
module req_flag_bank
   import intc_pkg::*;
(
   input  wire logic clock,   // System clock
   input  wire logic srst,    // Sync reset
   req_flag_if.bank  rf       // Flag controls
);
   typedef struct packed {
      logic [2:0] flags;
   } bank_s;

   bank_s st_reg;
   bank_s st_next;

   genvar i;
   logic [2:0] nxt;
   generate
      for (i = 0; i < 3; i++) begin : g_flag
         // Hardware events beat any clear in the same cycle
         always_comb begin
            nxt[i] = st_reg.flags[i];
            if (rf.ack[i]) begin
               nxt[i] = 1'b0;
            end
            if (rf.sw_wr[i]) begin
               nxt[i] = rf.sw_val[i];
            end
            if (i == `TMR_BIT && rf.tmr_clr) begin
               nxt[i] = 1'b0;
            end
            if (rf.events[i]) begin
               nxt[i] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      st_next = st_reg;
      st_next.flags = nxt;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rf.flags = st_reg.flags;
endmodule

// file: vectored_interrupt_control.sv
`timescale 1ns/1ps
`include "intc_params.svh"
module vectored_interrupt_control
   import intc_pkg::*;
(
   input  wire logic       clock,        // System clock, 25 MHz
   input  wire logic       srst,         // Sync reset, active high
   input  wire logic       pin_filtered, // Noise-filtered external pin
   input  wire logic       tmr_match,    // Timer count equals modulo
   input  wire logic       ser_done,     // Serial end of transfer
   input  wire logic       tmr_clear_bit,// Timer clear bit written with 1
   input  wire logic       stop_exec,    // Oscillator stop executed
   input  wire logic       set_global_en_op,       // Enable op this cycle
   input  wire logic       clr_global_en_op,       // Disable op this cycle
   input  wire logic       return_from_handler_op, // Return op this cycle
   input  wire logic       table_move_op,          // Table move in progress
   input  wire logic       skip_met,     // Skip condition met
   input  wire logic       reg_read_op,  // Register read strobe
   input  wire logic       reg_write_op, // Register write strobe
   input  wire logic [6:0] reg_addr,     // Register file address
   input  wire logic [3:0] reg_wdata,    // Write data
   input  wire pc_t        pc_in,        // Return address
   input  wire status_t    status_in,    // Live status word
   output logic [3:0]      reg_rdata,    // Read data
   output logic            reg_hit,      // Address is one of ours
   output logic [1:0]      cycle_phase,  // Current four-clock phase
   output logic            int_cycle,    // Preparation cycle running
   output logic            vector_load,  // Load vector into PC, one pulse
   output pc_t             vector_addr,  // Branch target
   output logic            stack_push,   // Push return address, one pulse
   output pc_t             push_addr,    // Address to push
   output logic            stack_pop,    // Pop address stack, one pulse
   output logic            status_load,  // Load status word, one pulse
   output status_t         status_out    // Value for the status word
);
   typedef struct packed {
      logic [3:0] clk_cnt;
      logic       global_en;
      logic       en_pend;
      logic       pin_last;
      logic [1:0] edge_sel;
      logic [2:0] src_en;
      logic [1:0] defer_cnt;
      logic       pending;
      source_e    pend_src;
      logic       in_int;
      status_t    int_stack;
      logic       vec_load;
      pc_t        vec;
      logic       push;
      pc_t        paddr;
      logic       pop;
      logic       sload;
      status_t    sval;
   } ctl_s;

   ctl_s st_reg;
   ctl_s st_next;

   req_flag_if rf ();

   req_flag_bank u_flags (
      .clock (clock),
      .srst  (srst),
      .rf    (rf)
   );

   logic       end_of_cycle;
   logic       recog_edge;
   logic       pin_rise;
   logic       pin_fall;
   logic       ext_event;
   logic [2:0] armed;
   source_e    winner;
   logic       wr_hit;

   assign end_of_cycle = (st_reg.clk_cnt == `LAST_CLOCK);
   assign recog_edge = (st_reg.clk_cnt == `RECOG_CLOCK);
   assign pin_rise = pin_filtered & ~st_reg.pin_last;
   assign pin_fall = ~pin_filtered & st_reg.pin_last;

   always_comb begin
      case (st_reg.edge_sel)
         `EDGE_RISE: ext_event = pin_rise;
         `EDGE_FALL: ext_event = pin_fall;
         default:    ext_event = pin_rise | pin_fall;
      endcase
   end

   assign armed = rf.flags & st_reg.src_en & {3{st_reg.global_en}};

   always_comb begin
      if (armed[`EXT_BIT]) begin
         winner = SRC_EXT;
      end else if (armed[`TMR_BIT]) begin
         winner = SRC_TMR;
      end else if (armed[`SER_BIT]) begin
         winner = SRC_SER;
      end else begin
         winner = SRC_NONE;
      end
   end

   assign wr_hit = reg_write_op & ~st_reg.in_int;
   assign rf.events = {ser_done, tmr_match, ext_event};
   assign rf.tmr_clr = tmr_clear_bit | stop_exec;
   assign rf.sw_val = {3{reg_wdata[0]}};
   assign rf.sw_wr = {wr_hit && reg_addr == `ADDR_SER_REQ,
                      wr_hit && reg_addr == `ADDR_TMR_REQ,
                      wr_hit && reg_addr == `ADDR_EXT_REQ};

   always_comb begin
      st_next = st_reg;
      st_next.vec_load = 1'b0;
      st_next.push = 1'b0;
      st_next.pop = 1'b0;
      st_next.sload = 1'b0;
      rf.ack = 3'h0;
      st_next.clk_cnt = st_reg.clk_cnt + 4'h1;
      st_next.pin_last = pin_filtered;

      if (reg_write_op) begin
         case (reg_addr)
            `ADDR_EDGE_SEL: st_next.edge_sel = reg_wdata[1:0];
            `ADDR_SRC_EN:   st_next.src_en = reg_wdata[2:0];
            default:        st_next.edge_sel = st_reg.edge_sel;
         endcase
      end

      // Enable waits for the following instruction to finish
      if (set_global_en_op && end_of_cycle) begin
         st_next.en_pend = 1'b1;
      end else if (st_reg.en_pend && end_of_cycle) begin
         st_next.en_pend = 1'b0;
         st_next.global_en = 1'b1;
      end
      if (clr_global_en_op) begin
         st_next.global_en = 1'b0;
         st_next.en_pend = 1'b0;
      end

      if (recog_edge && !st_reg.pending && !st_reg.in_int &&
          winner != SRC_NONE) begin
         st_next.pending = 1'b1;
         st_next.pend_src = winner;
         // Deferred ops hold acceptance back by one more whole cycle
         if (table_move_op || set_global_en_op || skip_met ||
             st_reg.en_pend) begin
            st_next.defer_cnt = `DEFER_CYCLES;
         end else begin
            st_next.defer_cnt = 2'h0;
         end
      end

      if (st_reg.pending && end_of_cycle) begin
         if (st_reg.defer_cnt > 2'h1) begin
            st_next.defer_cnt = st_reg.defer_cnt - 2'h1;
         end else begin
            st_next.pending = 1'b0;
            st_next.defer_cnt = 2'h0;
            st_next.in_int = 1'b1;
            st_next.push = 1'b1;
            st_next.paddr = pc_in;
            st_next.int_stack = status_in;
            st_next.sload = 1'b1;
            st_next.sval = `STATUS_CLEAR;
            st_next.vec_load = 1'b1;
            // Handler runs masked, as the single-level stack cannot nest
            st_next.global_en = 1'b0;
            st_next.en_pend = 1'b0;
            case (st_reg.pend_src)
               SRC_EXT: begin
                  st_next.vec = `VEC_EXT;
                  rf.ack[`EXT_BIT] = 1'b1;
               end
               SRC_TMR: begin
                  st_next.vec = `VEC_TMR;
                  rf.ack[`TMR_BIT] = 1'b1;
               end
               SRC_SER: begin
                  st_next.vec = `VEC_SER;
                  rf.ack[`SER_BIT] = 1'b1;
               end
               default: st_next.vec = st_reg.vec;
            endcase
         end
      end

      if (st_reg.in_int && end_of_cycle && !st_reg.push) begin
         st_next.in_int = 1'b0;
      end

      if (return_from_handler_op && end_of_cycle) begin
         // Global enable left as it is
         st_next.pop = 1'b1;
         st_next.sload = 1'b1;
         st_next.sval = st_reg.int_stack;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Global enable has no read path on purpose
   always_comb begin
      reg_hit = 1'b1;
      case (reg_addr)
         `ADDR_PIN_LEVEL: reg_rdata = {3'h0, pin_filtered};
         `ADDR_EDGE_SEL:  reg_rdata = {2'h0, st_reg.edge_sel};
         `ADDR_SRC_EN:    reg_rdata = {1'h0, st_reg.src_en};
         `ADDR_SER_REQ:   reg_rdata = {3'h0, rf.flags[`SER_BIT]};
         `ADDR_TMR_REQ:   reg_rdata = {3'h0, rf.flags[`TMR_BIT]};
         `ADDR_EXT_REQ:   reg_rdata = {3'h0, rf.flags[`EXT_BIT]};
         default: begin
            reg_rdata = 4'h0;
            reg_hit = 1'b0;
         end
      endcase
      if (!reg_read_op) begin
         reg_rdata = 4'h0;
      end
   end

   assign cycle_phase = st_reg.clk_cnt[3:2];
   assign int_cycle = st_reg.in_int;
   assign vector_load = st_reg.vec_load;
   assign vector_addr = st_reg.vec;
   assign stack_push = st_reg.push;
   assign push_addr = st_reg.paddr;
   assign stack_pop = st_reg.pop;
   assign status_load = st_reg.sload;
   assign status_out = st_reg.sval;
endmodule

// file: vic_sva.sv
`timescale 1ns/1ps
`include "intc_params.svh"
module vic_checker
   import intc_pkg::*;
(
   input wire logic       clock,       // Clock
   input wire logic       srst,        // Reset
   input wire logic [1:0] cycle_phase, // Phase
   input wire logic       int_cycle,   // Prep cycle
   input wire logic       vector_load, // Branch
   input wire pc_t        vector_addr, // Target
   input wire logic       stack_push,  // Push
   input wire logic       stack_pop,   // Pop
   input wire logic       status_load, // Status load
   input wire status_t    status_out   // Status value
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence accept_s;
      vector_load && stack_push && status_load;
   endsequence
   sequence steady_s;
      $stable(cycle_phase) [*3];
   endsequence
   save_all_a: assert property (vector_load |-> accept_s)
      else $error("accept without save");
   push_cause_a: assert property (stack_push |-> vector_load)
      else $error("push without accept");
   zero_status_a: assert property (
      accept_s |-> status_out == `STATUS_CLEAR) else $error("status kept");
   vector_code_a: assert property (vector_load |-> vector_addr inside
      {`VEC_EXT, `VEC_TMR, `VEC_SER}) else $error("bad vector");
   accept_start_a: assert property (
      vector_load |-> cycle_phase == 2'h0 && int_cycle) else $error("late");
   prep_hold_a: assert property (
      accept_s |=> !vector_load && int_cycle) else $error("prep broken");
   phase_len_a: assert property ($changed(cycle_phase) |=> steady_s)
      else $error("phase not 4 clocks");
   prep_end_a: assert property ($fell(int_cycle) |-> cycle_phase == 2'h0)
      else $error("prep cut short");
   return_pop_a: assert property (stack_pop |->
      status_load && !stack_push && cycle_phase == 2'h0) else $error("pop");
endmodule

// file: cpu_model.sv
`timescale 1ns/1ps
module cpu_model
   import intc_pkg::*;
(
   input  wire logic       clock,       // Clock
   input  wire logic       srst,        // Reset
   input  wire logic [2:0] op_req,      // Set, clear, return wanted
   input  wire logic       status_load, // Status load
   input  wire status_t    status_out,  // Status value
   output logic [2:0]      ops,         // Op of this cycle
   output status_t         status       // Live status word
);
   logic [3:0] cnt;
   // Counts in step with the block, as both leave reset on one edge
   always_ff @(posedge clock) begin
      if (srst) begin
         cnt    <= 4'h0;
         ops    <= 3'h0;
         status <= 5'h15;
      end else begin
         cnt <= cnt + 4'h1;
         if (cnt == 4'hF)
            ops <= op_req;
         if (status_load)
            status <= status_out;
      end
   end
endmodule

// file: tb_vectored_interrupt_control.sv
`timescale 1ns/1ps
`include "intc_params.svh"
module tb_vectored_interrupt_control;
   import intc_pkg::*;
   logic       clock, srst, pin_filtered, tmr_match, ser_done;
   logic       tmr_clear_bit, reg_read_op, reg_write_op, int_cycle;
   logic       vector_load, stack_push, stack_pop, status_load;
   logic [6:0] reg_addr;
   logic [3:0] reg_wdata, reg_rdata;
   logic [2:0] op_req, ops;
   logic [1:0] cycle_phase;
   pc_t        vector_addr, last_vec, push_addr;
   status_t    status_in, status_out;
   int         n_errors, tests_run, cyc, n_acc;
   pc_t        vecs [3] = '{`VEC_EXT, `VEC_TMR, `VEC_SER};
   logic [6:0] rqs [3] = '{`ADDR_EXT_REQ, `ADDR_TMR_REQ, `ADDR_SER_REQ};
   vectored_interrupt_control dut (.clock, .srst, .pin_filtered, .tmr_match,
      .ser_done, .tmr_clear_bit, .stop_exec(1'b0), .set_global_en_op(ops[2]),
      .clr_global_en_op(ops[1]), .return_from_handler_op(ops[0]),
      .table_move_op(1'b0), .skip_met(1'b0), .reg_read_op, .reg_write_op,
      .reg_addr, .reg_wdata, .pc_in(11'h123), .status_in, .reg_rdata,
      .reg_hit(), .cycle_phase, .int_cycle, .vector_load, .vector_addr,
      .stack_push, .push_addr, .stack_pop, .status_load, .status_out);
   cpu_model cpu (.clock, .srst, .op_req, .status_load, .status_out, .ops,
      .status(status_in));
   task automatic report_and_stop;
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Read data is combinational, so it is judged mid-cycle
   task automatic bus(input logic w, logic [6:0] a, logic [3:0] d);
      {reg_write_op, reg_read_op, reg_addr, reg_wdata} = {w, !w, a, d};
      #20;
      if (!w) check(11'(reg_rdata), 11'(d));
      idle(1);
      {reg_write_op, reg_read_op} = 2'h0;
      idle(1);
   endtask
   task automatic ev(input logic [2:0] v);
      {tmr_match, tmr_clear_bit, ser_done} = v;
      idle(1);
   endtask
   task automatic instr(input logic [2:0] op);
      op_req = op;
      do idle(1); while (ops !== op);
      op_req = 3'h0;
      do idle(1); while (ops !== 3'h0);
   endtask
   // Wait long enough to cover the delayed enable and the deferral
   task automatic acc(input logic [10:0] want, input pc_t vec);
      int k = n_acc;
      for (int i = 0; i < 64 && n_acc == k; i++) idle(1);
      check(11'(n_acc - k), want);
      if (want == 11'h1) check(last_vec, vec);
      if (want == 11'h1) check(push_addr, 11'h123);
      idle(16);
   endtask
   task automatic t_edge;
      logic r, f;
      bus(0, `ADDR_EDGE_SEL, 4'h0);
      for (int m = 0; m < 3; m++) begin
         r = (m != 1);
         f = (m != 0);
         bus(1, `ADDR_EDGE_SEL, 4'(m));
         bus(1, `ADDR_EXT_REQ, 4'h0);
         pin_filtered = 1'b1;
         bus(1, `ADDR_PIN_LEVEL, 4'h0);
         bus(0, `ADDR_PIN_LEVEL, 4'h1);
         bus(0, `ADDR_EXT_REQ, {3'h0, r});
         pin_filtered = 1'b0;
         idle(2);
         bus(0, `ADDR_EXT_REQ, {3'h0, r | f});
      end
   endtask
   task automatic t_accept;
      bus(1, `ADDR_SRC_EN, 4'h7);
      ev(3'h4);
      ev(3'h2);
      bus(0, `ADDR_TMR_REQ, 4'h0);
      ev(3'h5);
      ev(3'h0);
      bus(1, `ADDR_EXT_REQ, 4'h1);
      acc(11'h0, 11'h0);
      bus(1, `ADDR_SRC_EN, 4'h0);
      instr(3'h4);
      acc(11'h0, 11'h0);
      bus(1, `ADDR_SRC_EN, 4'h7);
      for (int i = 0; i < 3; i++) begin
         acc(11'h1, vecs[i]);
         check(11'(status_in), 11'h000);
         bus(0, rqs[i], 4'h0);
         instr(3'h2);
         instr(3'h1);
         acc(11'h0, 11'h0);
         check(11'(status_in), 11'h015);
         if (i < 2) instr(3'h4);
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (vector_load === 1'b1) begin
         n_acc++;
         last_vec = vector_addr;
      end
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop;
      end
   end
   initial begin
      srst = 1'b1;
      {pin_filtered, tmr_match, tmr_clear_bit, ser_done} = 4'h0;
      {reg_read_op, reg_write_op, reg_addr, reg_wdata} = 13'h0000;
      op_req = 3'h0;
      repeat (2) @(posedge clock);
      #1 srst = 1'b0;
      t_edge;
      t_accept;
      report_and_stop;
   end
endmodule
bind vectored_interrupt_control vic_checker chk (.clock, .srst, .cycle_phase,
   .int_cycle, .vector_load, .vector_addr, .stack_push, .stack_pop,
   .status_load, .status_out);
